// File: pkg/drb_pkg.sv
// drb_pkg: register map, field positions, masks and carrier types for the
// drive reference register bank.
// assumes: a frame decoder outside the bank hands over 16-bit register
// addresses and single data bytes; nothing here depends on the framing.
package drb_pkg;

  // register map, index = register number on the link
  localparam logic [15:0] OFS_RESERVED_ZERO  = 16'h0000;
  localparam logic [15:0] OFS_OP_CMD         = 16'h0001;
  localparam logic [15:0] OFS_FREQ_REF       = 16'h0002;
  localparam logic [15:0] OFS_RESERVED_THREE = 16'h0003;
  localparam logic [15:0] OFS_TORQUE_REF     = 16'h0004;
  localparam logic [15:0] OFS_TORQUE_COMP    = 16'h0005;
  localparam logic [15:0] OFS_PID_TARGET     = 16'h0006;
  localparam logic [15:0] OFS_AO1_SET        = 16'h0007;
  localparam logic [15:0] OFS_AO2_SET        = 16'h0008;
  localparam logic [15:0] OFS_CONTACT_CTL    = 16'h0009;
  localparam logic [15:0] OFS_RESERVED_FIRST = 16'h000A;
  localparam logic [15:0] OFS_RESERVED_LAST  = 16'h000E;
  localparam logic [15:0] OFS_REF_SELECT     = 16'h000F;
  localparam int unsigned REG_COUNT          = 16;
  localparam int unsigned REG_IDX_W          = 4;

  // implemented-bit masks; unused bits store nothing and read zero
  localparam logic [15:0] MASK_FULL          = 16'hFFFF;
  localparam logic [15:0] MASK_NONE          = 16'h0000;
  localparam logic [15:0] MASK_CONTACT_CTL   = 16'h00DF;
  localparam logic [15:0] MASK_REF_SELECT    = 16'hF002;

  // reset value of every implemented register
  localparam logic [15:0] RST_REG            = 16'h0000;

  // operation command word fields
  localparam int unsigned OP_RUN_BIT         = 0;
  localparam int unsigned OP_REVERSE_BIT     = 1;
  localparam int unsigned OP_EXT_FAULT_BIT   = 2;
  localparam int unsigned OP_FAULT_RESET_BIT = 3;
  localparam int unsigned OP_NET_REF_BIT     = 4;
  localparam int unsigned OP_CTRL_SRC_BIT    = 5;
  localparam int unsigned OP_MFI_LSB         = 6;
  localparam int unsigned OP_MFI_W           = 10;

  // contact output control fields
  localparam int unsigned CO_RELAY_LSB       = 0;
  localparam int unsigned CO_RELAY_W         = 3;
  localparam int unsigned CO_PHOTO3_BIT      = 3;
  localparam int unsigned CO_PHOTO4_BIT      = 4;
  localparam int unsigned CO_FAULT_OVR_BIT   = 6;
  localparam int unsigned CO_FAULT_ON_BIT    = 7;

  // reference selection fields
  localparam int unsigned RS_PID_LINK_BIT    = 1;
  localparam int unsigned RS_BCAST_LSB       = 12;
  localparam int unsigned RS_BCAST_W         = 4;

  // analog output scaling: count span and voltage ends in millivolts
  localparam int          AO_COUNT_MAX       = 1540;
  localparam int          AO1_POS_MV         = 10000;
  localparam int          AO1_NEG_MV         = 11000;
  localparam int          AO2_POS_MV         = 11000;
  localparam int          AO2_NEG_MV         = 11000;

  // access session opened by the frame decoder
  typedef struct packed {
    logic        start;
    logic        write;
    logic [15:0] addr;
  } drb_sess_t;

  // operation command as seen by the drive sequencer
  typedef struct packed {
    logic                run;
    logic                reverse;
    logic                link_external_fault;
    logic                fault_reset;
    logic                network_reference_select;
    logic                control_source_select;
    logic [OP_MFI_W-1:0] mfi;
  } drb_drive_cmd_t;

  // contact and photocoupler outputs
  typedef struct packed {
    logic [CO_RELAY_W-1:0] relay;
    logic                  photocoupler_output_three;
    logic                  photocoupler_output_four;
    logic                  fault_relay_forced;
    logic                  fault_relay_on;
  } drb_contacts_t;

  // byte engine states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b100
  } drb_state_t;

endpackage

// File: verilog/drb_ao_scale.sv
// drb_ao_scale: turns a signed analog output count into a millivolt level.
// assumes: the count is a register value that changes rarely; one cycle
// of latency is acceptable to the output stage.
module drb_ao_scale #(
  parameter int POS_MV = drb_pkg::AO1_POS_MV,
  parameter int NEG_MV = drb_pkg::AO1_NEG_MV
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic signed [15:0] count,
  output      logic signed [15:0] level_mv_q
);

  logic signed [31:0] count_ext;
  logic signed [31:0] clamped;
  logic signed [31:0] scaled;

  // clamp first so that out-of-span counts cannot overdrive the stage
  assign count_ext = 32'(count);
  assign clamped   = (count_ext >  drb_pkg::AO_COUNT_MAX) ?
                     32'(drb_pkg::AO_COUNT_MAX) :
                     (count_ext < -drb_pkg::AO_COUNT_MAX) ?
                     32'(-drb_pkg::AO_COUNT_MAX) : count_ext;

  // the two halves have their own slope, so the span may be asymmetric
  assign scaled = (clamped >= 0) ?
                  (clamped * POS_MV) / drb_pkg::AO_COUNT_MAX :
                  (clamped * NEG_MV) / drb_pkg::AO_COUNT_MAX;

  // registered level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_mv_q <= 16'sh0000;
    end else begin
      level_mv_q <= scaled[15:0];
    end
  end

endmodule

// File: verilog/drb_reg_bank.sv
// drb_reg_bank: read/write reference register bank of the motor drive,
// reached byte by byte from the serial link frame decoder.
// assumes: the decoder opens a session per frame with sess.start, then
// passes data bytes (write) or byte requests (read) and closes it with
// sess_end; frame checks are done before anything reaches this block.
module drb_reg_bank (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire drb_pkg::drb_sess_t     sess,
  input  wire logic                   sess_end,
  input  wire logic                   wr_byte_valid,
  input  wire logic [7:0]             wr_byte,
  input  wire logic                   rd_byte_req,
  output      logic [7:0]             rd_byte_q,
  output      logic                   rd_byte_valid_q,
  output      logic                   busy_q,
  output      logic                   wr_ignored_q,
  output      drb_pkg::drb_drive_cmd_t drive_cmd_q,
  output      logic [15:0]            frequency_reference_q,
  output      logic [15:0]            torque_reference_q,
  output      logic [15:0]            torque_compensation_q,
  output      logic [15:0]            pid_target_value_q,
  output      logic                   pid_target_from_link_q,
  output      logic signed [15:0]     ao1_level_mv_q,
  output      logic signed [15:0]     ao2_level_mv_q,
  output      drb_pkg::drb_contacts_t contacts_q,
  output      logic [3:0]             broadcast_input_enable_q
);

  // implemented-bit mask of a register number; zero marks reserved
  // one function keeps the write gate and the read path in step
  function automatic logic [15:0] reg_mask(input logic [15:0] addr);
    logic [15:0] m;
    m = drb_pkg::MASK_NONE;
    case (addr)
      drb_pkg::OFS_OP_CMD:      m = drb_pkg::MASK_FULL;
      drb_pkg::OFS_FREQ_REF:    m = drb_pkg::MASK_FULL;
      drb_pkg::OFS_TORQUE_REF:  m = drb_pkg::MASK_FULL;
      drb_pkg::OFS_TORQUE_COMP: m = drb_pkg::MASK_FULL;
      drb_pkg::OFS_PID_TARGET:  m = drb_pkg::MASK_FULL;
      drb_pkg::OFS_AO1_SET:     m = drb_pkg::MASK_FULL;
      drb_pkg::OFS_AO2_SET:     m = drb_pkg::MASK_FULL;
      drb_pkg::OFS_CONTACT_CTL: m = drb_pkg::MASK_CONTACT_CTL;
      drb_pkg::OFS_REF_SELECT:  m = drb_pkg::MASK_REF_SELECT;
      default:                  m = drb_pkg::MASK_NONE;
    endcase
    return m;
  endfunction

  // storage; reserved slots exist but their mask keeps them at zero
  logic [15:0]          regs_q [drb_pkg::REG_COUNT];

  drb_pkg::drb_state_t  state_q;
  drb_pkg::drb_state_t  state_d;
  logic [15:0]          ptr_q;
  logic [15:0]          ptr_d;
  logic                 lo_phase_q;
  logic                 lo_phase_d;
  logic [7:0]           hi_hold_q;

  logic                 in_write;
  logic                 in_read;
  logic                 wr_take;
  logic                 wr_word;
  logic                 rd_take;
  logic [15:0]          cur_mask;
  logic                 cur_mapped;
  logic [15:0]          wr_data;
  logic [15:0]          rd_word;
  logic [7:0]           rd_byte_d;
  logic [drb_pkg::REG_IDX_W-1:0] cur_idx;

  logic [15:0]          op_word;
  logic [15:0]          co_word;
  logic [15:0]          rs_word;

  // session and byte qualifiers
  assign in_write = (state_q == drb_pkg::ST_WRITE);
  assign in_read  = (state_q == drb_pkg::ST_READ);
  assign wr_take  = in_write && wr_byte_valid && !sess.start && !sess_end;
  assign rd_take  = in_read && rd_byte_req && !sess.start && !sess_end;
  assign wr_word  = wr_take && lo_phase_q;

  // address decode; anything past the bank counts as reserved
  // the pointer is not wrapped: a long session runs into the unmapped
  // range, so extra words are dropped instead of hitting reg 0
  assign cur_idx    = ptr_q[drb_pkg::REG_IDX_W-1:0];
  assign cur_mapped = (ptr_q[15:drb_pkg::REG_IDX_W] == 12'h000);
  assign cur_mask   = cur_mapped ? reg_mask(ptr_q) : drb_pkg::MASK_NONE;

  assign wr_data = {hi_hold_q, wr_byte} & cur_mask;
  assign rd_word = cur_mapped ? (regs_q[cur_idx] & cur_mask) : 16'h0000;
  assign rd_byte_d = lo_phase_q ? rd_word[7:0] : rd_word[15:8];

  // next state of the byte engine; a new start always wins over an end
  always_comb begin
    state_d    = state_q;
    ptr_d      = ptr_q;
    lo_phase_d = lo_phase_q;
    case (state_q)
      drb_pkg::ST_IDLE: begin
        state_d = drb_pkg::ST_IDLE;
      end
      drb_pkg::ST_WRITE: begin
        if (wr_take) begin
          lo_phase_d = !lo_phase_q;
          if (lo_phase_q) begin
            ptr_d = ptr_q + 16'h0001;
          end
        end
      end
      drb_pkg::ST_READ: begin
        if (rd_take) begin
          lo_phase_d = !lo_phase_q;
          if (lo_phase_q) begin
            ptr_d = ptr_q + 16'h0001;
          end
        end
      end
      default: begin
        state_d = drb_pkg::ST_IDLE;
      end
    endcase
    // an end clears the phase, so a lone high byte never commits
    if (sess_end) begin
      state_d    = drb_pkg::ST_IDLE;
      lo_phase_d = 1'b0;
    end
    if (sess.start) begin
      state_d    = sess.write ? drb_pkg::ST_WRITE : drb_pkg::ST_READ;
      ptr_d      = sess.addr;
      lo_phase_d = 1'b0;
    end
  end

  // engine registers; a dangling high byte is dropped at session end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= drb_pkg::ST_IDLE;
      ptr_q      <= 16'h0000;
      lo_phase_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      ptr_q      <= ptr_d;
      lo_phase_q <= lo_phase_d;
    end
  end

  // high byte holding stage
  // only the low byte commits a word, so the outputs never see a
  // register with one new half and one old half
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_hold_q <= 8'h00;
    end else if (wr_take && !lo_phase_q) begin
      hi_hold_q <= wr_byte;
    end
  end

  // masked store only
  // a reserved slot has mask zero, so a write to it stores nothing and it never
  // moves away from reset; the master is not trusted to avoid it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < drb_pkg::REG_COUNT; i++) begin
        regs_q[i] <= drb_pkg::RST_REG;
      end
    end else if (wr_word && (cur_mask != drb_pkg::MASK_NONE)) begin
      regs_q[cur_idx] <= wr_data;
    end
  end

  // flag ignored words
  // a word aimed at a reserved or unmapped address is dropped; the pulse
  // lets the decoder answer with an error if it wishes
  // not sticky, so nothing has to clear it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ignored_q <= 1'b0;
    end else begin
      wr_ignored_q <= wr_word && (cur_mask == drb_pkg::MASK_NONE);
    end
  end

  // read answer, one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_byte_q       <= 8'h00;
      rd_byte_valid_q <= 1'b0;
    end else begin
      rd_byte_valid_q <= rd_take;
      if (rd_take) begin
        rd_byte_q <= rd_byte_d;
      end
    end
  end

  // session status
  // follows the next state, so it rises one cycle after start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_d != drb_pkg::ST_IDLE);
    end
  end

  // named views of the control registers
  assign op_word = regs_q[drb_pkg::OFS_OP_CMD[drb_pkg::REG_IDX_W-1:0]];
  assign co_word = regs_q[drb_pkg::OFS_CONTACT_CTL[drb_pkg::REG_IDX_W-1:0]];
  assign rs_word = regs_q[drb_pkg::OFS_REF_SELECT[drb_pkg::REG_IDX_W-1:0]];

  // operation command fan-out; levels follow the register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_cmd_q <= '0;
    end else begin
      drive_cmd_q.run                 <= op_word[drb_pkg::OP_RUN_BIT];
      drive_cmd_q.reverse             <= op_word[drb_pkg::OP_REVERSE_BIT];
      drive_cmd_q.link_external_fault <=
        op_word[drb_pkg::OP_EXT_FAULT_BIT];
      drive_cmd_q.fault_reset         <=
        op_word[drb_pkg::OP_FAULT_RESET_BIT];
      drive_cmd_q.network_reference_select <=
        op_word[drb_pkg::OP_NET_REF_BIT];
      drive_cmd_q.control_source_select    <=
        op_word[drb_pkg::OP_CTRL_SRC_BIT];
      drive_cmd_q.mfi <= op_word[drb_pkg::OP_MFI_LSB +: drb_pkg::OP_MFI_W];
    end
  end

  // numeric references; units are decided by the frequency unit constant
  // outside this block, so the bank passes the raw value through
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frequency_reference_q <= drb_pkg::RST_REG;
      torque_reference_q    <= drb_pkg::RST_REG;
      torque_compensation_q <= drb_pkg::RST_REG;
      pid_target_value_q    <= drb_pkg::RST_REG;
    end else begin
      frequency_reference_q <=
        regs_q[drb_pkg::OFS_FREQ_REF[drb_pkg::REG_IDX_W-1:0]];
      torque_reference_q    <=
        regs_q[drb_pkg::OFS_TORQUE_REF[drb_pkg::REG_IDX_W-1:0]];
      torque_compensation_q <=
        regs_q[drb_pkg::OFS_TORQUE_COMP[drb_pkg::REG_IDX_W-1:0]];
      pid_target_value_q    <=
        regs_q[drb_pkg::OFS_PID_TARGET[drb_pkg::REG_IDX_W-1:0]];
    end
  end

  // reference selection fan-out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pid_target_from_link_q   <= 1'b0;
      broadcast_input_enable_q <= 4'h0;
    end else begin
      pid_target_from_link_q   <= rs_word[drb_pkg::RS_PID_LINK_BIT];
      broadcast_input_enable_q <=
        rs_word[drb_pkg::RS_BCAST_LSB +: drb_pkg::RS_BCAST_W];
    end
  end

  // contact outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      contacts_q <= '0;
    end else begin
      contacts_q.relay <=
        co_word[drb_pkg::CO_RELAY_LSB +: drb_pkg::CO_RELAY_W];
      contacts_q.photocoupler_output_three <=
        co_word[drb_pkg::CO_PHOTO3_BIT];
      contacts_q.photocoupler_output_four  <=
        co_word[drb_pkg::CO_PHOTO4_BIT];
      // forced fault relay
      // without the override the fault relay stays with the fault logic,
      // so fault_relay_on is only meaningful while the override is set
      contacts_q.fault_relay_forced <= co_word[drb_pkg::CO_FAULT_OVR_BIT];
      contacts_q.fault_relay_on     <= co_word[drb_pkg::CO_FAULT_OVR_BIT] &&
                                       co_word[drb_pkg::CO_FAULT_ON_BIT];
    end
  end

  // the two outputs differ only in the positive end of their span
  // analog output one
  drb_ao_scale #(
    .POS_MV (drb_pkg::AO1_POS_MV),
    .NEG_MV (drb_pkg::AO1_NEG_MV)
  ) u_ao1 (
    .clk        (clk),
    .rst_n      (rst_n),
    .count      (regs_q[drb_pkg::OFS_AO1_SET[drb_pkg::REG_IDX_W-1:0]]),
    .level_mv_q (ao1_level_mv_q)
  );

  drb_ao_scale #(
    .POS_MV (drb_pkg::AO2_POS_MV),
    .NEG_MV (drb_pkg::AO2_NEG_MV)
  ) u_ao2 (
    .clk        (clk),
    .rst_n      (rst_n),
    .count      (regs_q[drb_pkg::OFS_AO2_SET[drb_pkg::REG_IDX_W-1:0]]),
    .level_mv_q (ao2_level_mv_q)
  );

endmodule

// File: verification/drb_reg_bank_props.sv
// drb_reg_bank_props: timing checks on the register bank byte port.
// assumes: bound to drb_reg_bank; one clock, async active-low reset.
module drb_reg_bank_props (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire drb_pkg::drb_sess_t      sess,
  input wire logic                    sess_end,
  input wire logic                    wr_byte_valid,
  input wire logic                    rd_byte_req,
  input wire logic                    rd_byte_valid_q,
  input wire logic                    busy_q,
  input wire logic                    wr_ignored_q,
  input wire drb_pkg::drb_drive_cmd_t drive_cmd_q,
  input wire logic [15:0]             frequency_reference_q,
  input wire logic signed [15:0]      ao1_level_mv_q,
  input wire logic signed [15:0]      ao2_level_mv_q,
  input wire drb_pkg::drb_contacts_t  contacts_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic      rd_mode_q;
  wire logic rd_take;
  // a request counts only inside an open read session
  assign rd_take = busy_q && rd_mode_q && rd_byte_req && !sess.start
                   && !sess_end;

  // session kind comes only with the start pulse, so it is kept here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rd_mode_q <= 1'b0;
    else if (sess.start) rd_mode_q <= !sess.write;
  end

  property p_rd_answer;
    rd_take |=> rd_byte_valid_q;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read byte answer missing");
  property p_rd_only;
    !rd_take |=> !rd_byte_valid_q;
  endproperty
  a_rd_only: assert property (p_rd_only)
    else $error("read byte answer without request");
  property p_busy_open;
    sess.start |=> busy_q;
  endproperty
  a_busy_open: assert property (p_busy_open)
    else $error("session not open after start");
  property p_busy_close;
    sess_end && !sess.start |=> !busy_q;
  endproperty
  a_busy_close: assert property (p_busy_close)
    else $error("session still open after end");
  property p_out_cause;
    $changed(drive_cmd_q) || $changed(contacts_q)
      || $changed(frequency_reference_q) |-> $past(wr_byte_valid, 2);
  endproperty
  a_out_cause: assert property (p_out_cause)
    else $error("output changed without a written low byte");
  property p_ao_cause;
    $changed(ao1_level_mv_q) || $changed(ao2_level_mv_q)
      |-> $past(wr_byte_valid, 2);
  endproperty
  a_ao_cause: assert property (p_ao_cause)
    else $error("analog level changed without a write");
  property p_fault_relay;
    contacts_q.fault_relay_on |-> contacts_q.fault_relay_forced;
  endproperty
  a_fault_relay: assert property (p_fault_relay)
    else $error("fault relay on while not forced");
  property p_ao1_span;
    ao1_level_mv_q >= -drb_pkg::AO1_NEG_MV
      && ao1_level_mv_q <= drb_pkg::AO1_POS_MV;
  endproperty
  a_ao1_span: assert property (p_ao1_span)
    else $error("analog output one out of span");
  property p_ao2_span;
    ao2_level_mv_q >= -drb_pkg::AO2_NEG_MV
      && ao2_level_mv_q <= drb_pkg::AO2_POS_MV;
  endproperty
  a_ao2_span: assert property (p_ao2_span)
    else $error("analog output two out of span");
  property p_ign_pulse;
    wr_ignored_q |-> $past(wr_byte_valid) ##1 !wr_ignored_q;
  endproperty
  a_ign_pulse: assert property (p_ign_pulse)
    else $error("ignored-write pulse malformed");

  c_read: cover property (rd_byte_valid_q);
  c_ignored: cover property (wr_ignored_q);
  c_fault_on: cover property (contacts_q.fault_relay_on);
endmodule

// File: verification/drb_link_master.sv
// drb_link_master: frame decoder side model driving the bank byte port.
// assumes: the bench calls xfer; all outputs change by NBA at rising edge.
module drb_link_master (
  input  wire logic         clk,
  output drb_pkg::drb_sess_t sess,
  output logic              sess_end,
  output logic              wr_byte_valid,
  output logic [7:0]        wr_byte,
  output logic              rd_byte_req
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] last_q;

  // quiet port at time zero
  initial begin
    sess = '0;
    sess_end = 1'b0;
    wr_byte_valid = 1'b0;
    wr_byte = 8'h00;
    rd_byte_req = 1'b0;
    last_q = 8'h00;
  end

  // one cycle; idle data shows the inverse so stale bytes never match
  task automatic step(input logic st, w, input logic [15:0] a,
                      input logic e, v, input logic [7:0] b,
                      input logic r);
    @(posedge clk);
    sess <= '{start: st, write: w, addr: a};
    sess_end <= e;
    wr_byte_valid <= v;
    wr_byte <= v ? b : ~last_q;
    rd_byte_req <= r;
    if (v) last_q = b;
  endtask

  // high byte first, words in rising address order
  // the byte order is kept here; the caller orders the words in d
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [15:0] d[$], input int n,
                      input int gap);
    logic [7:0] b;
    step(1'b1, w, a, 1'b0, 1'b0, 8'h00, 1'b0);
    for (int i = 0; i < 2 * n; i++) begin
      b = !w ? 8'h00 : i[0] ? d[i/2][7:0] : d[i/2][15:8];
      repeat (gap) step(1'b0, w, a, 1'b0, 1'b0, 8'h00, 1'b0);
      step(1'b0, w, a, 1'b0, w, b, !w);
    end
    step(1'b0, w, a, 1'b1, 1'b0, 8'h00, 1'b0);
    step(1'b0, 1'b0, 16'h0000, 1'b0, 1'b0, 8'h00, 1'b0);
  endtask
endmodule

// File: verification/drb_tb.sv
// drb_tb: self-checking bench for the reference register bank.
// assumes: drb_link_master drives the byte port; read bytes are checked
// against a queue of expected values filled before each read.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  drb_pkg::drb_sess_t      sess;
  logic                    sess_end, wr_byte_valid, rd_byte_req;
  logic [7:0]              wr_byte, rd_byte_q;
  logic                    rd_byte_valid_q, busy_q, wr_ignored_q;
  drb_pkg::drb_drive_cmd_t drive_cmd_q;
  logic [15:0]             freq_q, torq_q, comp_q, pid_q;
  logic                    pid_link_q;
  logic signed [15:0]      ao1_q, ao2_q;
  drb_pkg::drb_contacts_t  contacts_q;
  logic [3:0]              bcast_q;
  logic [15:0]             mdl [16];
  logic [15:0]             nil [$];
  logic [7:0]              exp_q [$];
  int                      fails = 0, cmp_count = 0, ign_cnt = 0;

  always #2.5 clk = ~clk;

  drb_link_master u_link (.clk(clk), .sess(sess), .sess_end(sess_end),
    .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte),
    .rd_byte_req(rd_byte_req));

  drb_reg_bank u_dut (.clk(clk), .rst_n(rst_n), .sess(sess),
    .sess_end(sess_end), .wr_byte_valid(wr_byte_valid),
    .wr_byte(wr_byte), .rd_byte_req(rd_byte_req), .rd_byte_q(rd_byte_q),
    .rd_byte_valid_q(rd_byte_valid_q), .busy_q(busy_q),
    .wr_ignored_q(wr_ignored_q), .drive_cmd_q(drive_cmd_q),
    .frequency_reference_q(freq_q), .torque_reference_q(torq_q),
    .torque_compensation_q(comp_q), .pid_target_value_q(pid_q),
    .pid_target_from_link_q(pid_link_q), .ao1_level_mv_q(ao1_q),
    .ao2_level_mv_q(ao2_q), .contacts_q(contacts_q),
    .broadcast_input_enable_q(bcast_q));

  task automatic check(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // stored bits of each register; reserved places keep none
  function automatic logic [15:0] msk(input int i);
    if (i == 9) return drb_pkg::MASK_CONTACT_CTL;
    if (i == 15) return drb_pkg::MASK_REF_SELECT;
    if (i == 0 || i == 3 || (i > 9 && i < 15)) return drb_pkg::MASK_NONE;
    return drb_pkg::MASK_FULL;
  endfunction

  // clamp then scale, truncating toward zero
  function automatic logic [15:0] ao_mv(input logic [15:0] r,
                                        input int pos, neg);
    int c;
    c = int'(signed'(r));
    if (c > drb_pkg::AO_COUNT_MAX) c = drb_pkg::AO_COUNT_MAX;
    if (c < -drb_pkg::AO_COUNT_MAX) c = -drb_pkg::AO_COUNT_MAX;
    return 16'((c * (c > 0 ? pos : neg)) / drb_pkg::AO_COUNT_MAX);
  endfunction

  // let analog levels land, then compare every register-fed output (not busy, read or ignored flags) with the model
  task automatic settle_check();
    drb_pkg::drb_drive_cmd_t c;
    drb_pkg::drb_contacts_t  o;
    logic [15:0]             r, t;
    repeat (2) @(posedge clk);
    #1;
    r = mdl[1];
    t = mdl[9];
    c = '{r[0], r[1], r[2], r[3], r[4], r[5], r[15:6]};
    o = '{t[2:0], t[3], t[4], t[6], t[6] & t[7]};
    check("cmd", 16'(drive_cmd_q), 16'(c));
    check("freq", freq_q, mdl[2]);
    check("torq", torq_q, mdl[4]);
    check("comp", comp_q, mdl[5]);
    check("pid", pid_q, mdl[6]);
    check("pid_sel", 16'(pid_link_q), 16'(mdl[15][1]));
    check("bcast", 16'(bcast_q), 16'(mdl[15][15:12]));
    check("contacts", 16'(contacts_q), 16'(o));
    check("ao1", ao1_q, ao_mv(mdl[7], drb_pkg::AO1_POS_MV,
          drb_pkg::AO1_NEG_MV));
    check("ao2", ao2_q, ao_mv(mdl[8], drb_pkg::AO2_POS_MV,
          drb_pkg::AO2_NEG_MV));
  endtask

  task automatic read_back(input int gap);
    for (int i = 0; i < 16; i++) begin
      exp_q.push_back(mdl[i][15:8]);
      exp_q.push_back(mdl[i][7:0]);
    end
    u_link.xfer(1'b0, 16'h0000, nil, 16, gap);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (mdl[i]) mdl[i] = 16'h0000;
  endtask

  // answered bytes against the oldest note; count ignored writes
  always @(posedge clk) begin
    if (wr_ignored_q === 1'b1) ign_cnt++;
    if (rd_byte_valid_q === 1'b1)
      check("rd_byte", 16'(rd_byte_q),
            16'(exp_q.size() ? exp_q.pop_front() : 8'hxx));
  end

  // no hang outlives this bound
  initial begin
    repeat (50000) @(posedge clk);
    fails++;
    stop_test();
  end

  initial begin
    logic [15:0] qa [$], qb [$], qc [$];
    logic [15:0] v;
    int          gap;
    void'($urandom(38843));
    do_reset();
    settle_check();
    // random words, unused bits left random and fault relay bits forced in pass 0, sessions of 2, 6 and 1
    for (int k = 0; k < 6; k++) begin
      qa = {};
      qb = {};
      qc = {};
      for (int i = 1; i < 16; i++) begin
        v = (i == 7 || i == 8) ? 16'($urandom_range(3200) - 1600)
                               : 16'($urandom);
        if (k == 0 && i == 9) v = v | 16'h00C0;
        // later passes clear the unused bits
        if (k > 0) v = v & msk(i);
        if (i < 3) qa.push_back(v);
        else if (i > 3 && i < 10) qb.push_back(v);
        else if (i == 15) qc.push_back(v);
        mdl[i] = v & msk(i);
      end
      gap = $urandom_range(2);
      u_link.xfer(1'b1, 16'h0001, qa, 2, gap);
      u_link.xfer(1'b1, 16'h0004, qb, 6, gap);
      u_link.xfer(1'b1, 16'h000F, qc, 1, 0);
      settle_check();
      read_back(gap);
    end
    // reserved writes store nothing and pulse the ignored flag
    qa = {16'h1234};
    qb = {16'hFFFF, 16'h5A5A, 16'hA5A5, 16'h0F0F, 16'hF0F0};
    u_link.xfer(1'b1, 16'h0000, qa, 1, 0);
    u_link.xfer(1'b1, 16'h0003, qa, 1, 1);
    u_link.xfer(1'b1, 16'h0010, qa, 1, 0);
    u_link.xfer(1'b1, 16'h000A, qb, 5, 0);
    settle_check();
    check("ignored", 16'(ign_cnt), 16'h0008);
    read_back(0);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
    u_link.xfer(1'b0, 16'h0010, nil, 1, 0);
    // second reset in mid-run clears every register
    do_reset();
    settle_check();
    read_back(1);
    repeat (2) @(posedge clk);
    check("rd_left", 16'(exp_q.size()), 16'h0000);
    stop_test();
  end
endmodule

bind drb_reg_bank drb_reg_bank_props u_props (.clk(clk), .rst_n(rst_n),
  .sess(sess), .sess_end(sess_end), .wr_byte_valid(wr_byte_valid),
  .rd_byte_req(rd_byte_req), .rd_byte_valid_q(rd_byte_valid_q),
  .busy_q(busy_q), .wr_ignored_q(wr_ignored_q),
  .drive_cmd_q(drive_cmd_q),
  .frequency_reference_q(frequency_reference_q),
  .ao1_level_mv_q(ao1_level_mv_q), .ao2_level_mv_q(ao2_level_mv_q),
  .contacts_q(contacts_q));
